// ===== shared/cfr_pkg.sv
// Purpose: Constants for the control frame register writer
// Assumes: AXI4-Lite, 32-bit data, one word per register
package cfr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] CFG_IDX = 8'h1f;
	localparam logic [7:0] IRQ_STS_IDX = 8'h20;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
	// Config field positions
	localparam int ERR_BIT = 15;
	localparam int OK_BIT = 14;
	localparam int SEL_BIT = 8;
	localparam int IRQ_LO = 6;
	localparam int BCDIS_BIT = 5;
	localparam int BUF_LO = 1;
	localparam int EN_BIT = 0;
	// Writable config bits: 8:1 under this mask, bit 0 written apart (13:9 reserved, 15:14 read-only)
	localparam logic [15:0] CFG_WR_MASK = 16'h01fe;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	// Status register bit: receive-half-full slot
	localparam int SLOT_BIT = 0;
	localparam logic [4:0] BCAST_ADDR = 5'h1f;
	// Frame layout in bytes from first destination octet
	localparam logic [3:0] DA_LAST = 4'h5;
	localparam logic [3:0] TGT_POS = 4'h6;
	localparam logic [3:0] REG_POS = 4'h7;
	localparam logic [3:0] DHI_POS = 4'h8;
	localparam logic [3:0] DLO_POS = 4'h9;
	localparam logic [3:0] FRAME_DONE = 4'ha;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		PARSE_IDLE = 2'b00,
		PARSE_HIT = 2'b01,
		PARSE_SKIP = 2'b10
	} parse_e;
endpackage

// ===== rtl/control_frame_register_writer.sv
// Purpose: Control frame detection, transmit delay and config registers
// Assumes: tx_data starts at the first destination octet, one byte a cycle
// Notes: Frame body: target, register, data high, data low after the DA
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module control_frame_register_writer #(
	parameter logic [47:0] DEST_ADDR_A = 48'h0a_11_22_33_44_55, // arbitrary
	parameter logic [47:0] DEST_ADDR_B = 48'h0a_11_22_00_00_00, // arbitrary
	parameter int BUF_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic strap_frame_enable,
	input wire logic [4:0] own_phy_addr,
	input wire logic receive_half_full_irq,
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic [7:0] tx_data,
	output logic out_tx_en,
	output logic [7:0] out_tx_data,
	output logic frame_reg_wr,
	output logic [4:0] frame_reg_addr,
	output logic [15:0] frame_reg_data,
	output logic irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [15:0] cfg_reg, cfg_next;
	logic irq_sts_reg, irq_sts_next;
	logic irq_mask_reg, irq_mask_next;
	logic aw_held_reg, aw_held_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic w_held_reg, w_held_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	cfr_pkg::parse_e parse_reg, parse_next;
	logic [3:0] pos_reg, pos_next;
	logic [4:0] wr_addr_reg, wr_addr_next;
	logic [15:0] wr_data_reg, wr_data_next;
	logic wr_reg, wr_next;
	logic irq_reg, irq_next;
	logic [8:0] dly_reg [BUF_DEPTH];
	logic out_en_reg, out_en_next;
	logic [7:0] out_data_reg, out_data_next;

	// ------------------------------------------------------------
	// Combinational helpers
	// ------------------------------------------------------------
	logic [47:0] sel_addr;
	logic [7:0] exp_byte;
	logic byte_match;
	logic [3:0] buf_size;
	logic wr_do, rd_do, cfg_read;
	logic ev_good, ev_err, frame_end, cut;
	logic [8:0] tap;
	logic [15:0] wmask;

	always_comb begin
		sel_addr = cfg_reg[cfr_pkg::SEL_BIT] ? DEST_ADDR_B : DEST_ADDR_A;
		exp_byte = sel_addr[47 - 8 * pos_reg[2:0] -: 8];
		if (pos_reg == 4'h0) begin
			// Multicast bit of first octet may be set or clear
			byte_match = (tx_data | 8'h01) == (exp_byte | 8'h01);
		end else begin
			byte_match = tx_data == exp_byte;
		end
		buf_size = cfg_reg[cfr_pkg::BUF_LO +: 4];
		wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
		rd_do = s_axi_arvalid && !rvalid_reg;
		cfg_read = rd_do && (s_axi_araddr == {cfr_pkg::CFG_IDX[5:0], 2'b00});
		frame_end = !tx_en && (parse_reg == cfr_pkg::PARSE_HIT);
		ev_good = frame_end && (pos_reg == cfr_pkg::FRAME_DONE);
		// Short frame or coding error inside a control frame
		ev_err = (frame_end && (pos_reg != cfr_pkg::FRAME_DONE))
			|| (tx_en && tx_er && (parse_reg == cfr_pkg::PARSE_HIT));
		cut = (buf_size == 4'h0) && (parse_reg == cfr_pkg::PARSE_HIT)
			&& (pos_reg > cfr_pkg::DA_LAST);
		if (buf_size == 4'h0) begin
			tap = {tx_en, tx_data};
		end else begin
			tap = dly_reg[buf_size - 4'h1];
		end
		wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		cfg_next = cfg_reg;
		irq_sts_next = irq_sts_reg;
		irq_mask_next = irq_mask_reg;
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next = w_held_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		parse_next = parse_reg;
		pos_next = pos_reg;
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		wr_next = 1'b0;

		// Write address and data are taken independently
		if (s_axi_awvalid && !aw_held_reg) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held_reg) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_do) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = cfr_pkg::RESP_OKAY;
			if (aw_addr_reg == {cfr_pkg::CFG_IDX[5:0], 2'b00}) begin
				// Status and reserved bits never take written data
				cfg_next = (cfg_reg & ~(wmask & cfr_pkg::CFG_WR_MASK))
					| (w_data_reg[15:0] & wmask & cfr_pkg::CFG_WR_MASK);
				if (w_strb_reg[0]) begin
					cfg_next[cfr_pkg::EN_BIT] = w_data_reg[cfr_pkg::EN_BIT];
				end
			end else if (aw_addr_reg == {cfr_pkg::IRQ_STS_IDX[5:0], 2'b00}) begin
				if (w_strb_reg[0] && w_data_reg[cfr_pkg::SLOT_BIT]) begin
					irq_sts_next = 1'b0;
				end
			end else if (aw_addr_reg == {cfr_pkg::IRQ_MASK_IDX[5:0], 2'b00}) begin
				if (w_strb_reg[0]) begin
					irq_mask_next = w_data_reg[cfr_pkg::SLOT_BIT];
				end
			end else begin
				bresp_next = cfr_pkg::RESP_SLVERR;
			end
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end

		if (rd_do) begin
			rvalid_next = 1'b1;
			rresp_next = cfr_pkg::RESP_OKAY;
			rdata_next = 32'h0000_0000;
			if (cfg_read) begin
				rdata_next[15:0] = cfg_reg;
				// Clear on read; a flag set this cycle survives below
				cfg_next[cfr_pkg::ERR_BIT] = 1'b0;
				cfg_next[cfr_pkg::OK_BIT] = 1'b0;
			end else if (s_axi_araddr == {cfr_pkg::IRQ_STS_IDX[5:0], 2'b00}) begin
				rdata_next[cfr_pkg::SLOT_BIT] = irq_sts_reg;
			end else if (s_axi_araddr == {cfr_pkg::IRQ_MASK_IDX[5:0], 2'b00}) begin
				rdata_next[cfr_pkg::SLOT_BIT] = irq_mask_reg;
			end else begin
				rresp_next = cfr_pkg::RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end

		// Frame parser
		case (parse_reg)
			cfr_pkg::PARSE_IDLE: begin
				if (tx_en) begin
					pos_next = 4'h1;
					parse_next = cfr_pkg::PARSE_HIT;
					if (!byte_match) begin
						parse_next = cfr_pkg::PARSE_SKIP;
					end
				end
			end
			cfr_pkg::PARSE_HIT: begin
				if (!tx_en || tx_er) begin
					parse_next = tx_en ? cfr_pkg::PARSE_SKIP : cfr_pkg::PARSE_IDLE;
					pos_next = 4'h0;
				end else begin
					if (pos_reg != cfr_pkg::FRAME_DONE) begin
						pos_next = pos_reg + 4'h1;
					end
					if (pos_reg <= cfr_pkg::DA_LAST && !byte_match) begin
						parse_next = cfr_pkg::PARSE_SKIP;
					end
					if (pos_reg == cfr_pkg::TGT_POS) begin
						// Target field: own address, or broadcast unless disabled
						if (!(tx_data[4:0] == own_phy_addr
							|| (tx_data[4:0] == cfr_pkg::BCAST_ADDR
							&& !cfg_reg[cfr_pkg::BCDIS_BIT]))) begin
							parse_next = cfr_pkg::PARSE_SKIP;
						end
					end
					if (pos_reg == cfr_pkg::REG_POS) begin
						wr_addr_next = tx_data[4:0];
					end
					if (pos_reg == cfr_pkg::DHI_POS) begin
						wr_data_next[15:8] = tx_data;
					end
					if (pos_reg == cfr_pkg::DLO_POS) begin
						wr_data_next[7:0] = tx_data;
						wr_next = cfg_reg[cfr_pkg::EN_BIT];
					end
				end
			end
			default: begin
				pos_next = 4'h0;
				if (!tx_en) begin
					parse_next = cfr_pkg::PARSE_IDLE;
				end
			end
		endcase

		if (ev_err) begin
			cfg_next[cfr_pkg::ERR_BIT] = 1'b1;
		end
		if (ev_good) begin
			cfg_next[cfr_pkg::OK_BIT] = 1'b1;
		end

		// Shared status slot: frame events when enabled, else half-full
		if (cfg_reg[cfr_pkg::IRQ_LO +: 2] != 2'b00) begin
			if ((ev_good && cfg_reg[cfr_pkg::IRQ_LO])
				|| (ev_err && cfg_reg[cfr_pkg::IRQ_LO + 1])) begin
				irq_sts_next = 1'b1;
			end
		end else if (receive_half_full_irq) begin
			irq_sts_next = 1'b1;
		end

		irq_next = irq_sts_next & irq_mask_next;
		out_en_next = tap[8] && !cut;
		out_data_next = cut ? 8'h00 : tap[7:0];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= cfr_pkg::CFG_RESET;
			// Strap caught while reset is held
			cfg_reg[cfr_pkg::EN_BIT] <= strap_frame_enable;
			irq_sts_reg <= 1'b0;
			irq_mask_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= cfr_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= cfr_pkg::RESP_OKAY;
			parse_reg <= cfr_pkg::PARSE_IDLE;
			pos_reg <= 4'h0;
			wr_addr_reg <= 5'h00;
			wr_data_reg <= 16'h0000;
			wr_reg <= 1'b0;
			irq_reg <= 1'b0;
			out_en_reg <= 1'b0;
			out_data_reg <= 8'h00;
		end else begin
			cfg_reg <= cfg_next;
			irq_sts_reg <= irq_sts_next;
			irq_mask_reg <= irq_mask_next;
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg <= w_held_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			parse_reg <= parse_next;
			pos_reg <= pos_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
			wr_reg <= wr_next;
			irq_reg <= irq_next;
			out_en_reg <= out_en_next;
			out_data_reg <= out_data_next;
		end
	end

	// Delay line; contents need no reset since taps are gated by depth
	always_ff @(posedge aclk) begin
		dly_reg[0] <= {tx_en, tx_data};
		for (int i = 1; i < BUF_DEPTH; i++) begin
			dly_reg[i] <= dly_reg[i - 1];
		end
	end

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign out_tx_en = out_en_reg;
	assign out_tx_data = out_data_reg;
	assign frame_reg_wr = wr_reg;
	assign frame_reg_addr = wr_addr_reg;
	assign frame_reg_data = wr_data_reg;
	assign irq = irq_reg;
endmodule

// ===== verif/cfr_chk.sv
// Purpose: Port assertions for the control frame register writer
// Assumes: Config register answers at byte 0x7c
// Notes: Quiet-line bound covers the deepest detection buffer
`timescale 1ns/10ps
module cfr_chk #(
	parameter int BUF_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic tx_en,
	input wire logic out_tx_en,
	input wire logic frame_reg_wr
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] ra_reg;
	logic [7:0] ra_next;
	logic [5:0] idle_reg;
	logic [5:0] idle_next;
	always_comb begin
		ra_next = s_axi_arvalid && s_axi_arready ? s_axi_araddr : ra_reg;
		idle_next = tx_en ? 6'h00 : idle_reg + {5'h00, idle_reg != 6'h3f};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ra_reg <= 8'h00;
			idle_reg <= 6'h00;
		end else begin
			ra_reg <= ra_next;
			idle_reg <= idle_next;
		end
	end
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_stall;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_holds: assert property (s_rd_stall |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_upper_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_reserved_zero: assert property (s_axi_rvalid && ra_reg == 8'h7c |->
		s_axi_rdata[13:9] == 5'h00)
		else $error("reserved config bits set");
	a_wr_pulse: assert property (frame_reg_wr |=> !frame_reg_wr)
		else $error("frame write longer than a cycle");
	a_wr_after_byte: assert property (frame_reg_wr |-> $past(tx_en))
		else $error("frame write without a byte");
	a_tx_quiet: assert property (idle_reg > BUF_DEPTH + 1 |-> !out_tx_en)
		else $error("output beyond buffer delay");
endmodule
bind control_frame_register_writer cfr_chk #(.BUF_DEPTH(BUF_DEPTH)) i_chk (.*);

// ===== verif/cfr_mac_model.sv
// Purpose: Behavioural MAC feeding the transmit input
// Assumes: One frame per go request, first octet first
// Notes: Short frames carry an error mark on byte 6
`timescale 1ns/10ps
module cfr_mac_model (
	input wire logic aclk,
	input wire logic go,
	input wire logic [79:0] frame,
	input wire logic [3:0] nbytes,
	input wire logic bad,
	output logic busy,
	output logic tx_en,
	output logic tx_er,
	output logic [7:0] tx_data
);
	initial begin
		busy = 1'b0;
		tx_en = 1'b0;
		tx_er = 1'b0;
		tx_data = 8'h00;
		forever begin
			@(posedge aclk);
			if (go) begin
				busy <= 1'b1;
				for (int i = 0; i < nbytes; i++) begin
					tx_en <= 1'b1;
					tx_er <= bad && i == 6;
					tx_data <= frame[79 - 8 * i -: 8];
					@(posedge aclk);
				end
				// Released line: a stale byte would hide a missed enable
				tx_en <= 1'b0;
				tx_er <= 1'b0;
				tx_data <= ~tx_data;
				busy <= 1'b0;
			end
		end
	end
endmodule

// ===== verif/control_frame_register_writer_tb.sv
// Purpose: Self-checking bench for the control frame register writer
// Assumes: One frame at a time with an idle gap
// Notes: Reads and frame writes are scored from queues
`timescale 1ns/10ps
module control_frame_register_writer_tb;
	localparam logic [47:0] DA_A = 48'h0a1122334455; // arbitrary
	localparam logic [47:0] DA_B = 48'h0a1122000000; // arbitrary
	localparam logic [7:0] CFG = cfr_pkg::CFG_IDX << 2;
	localparam logic [7:0] STS = cfr_pkg::IRQ_STS_IDX << 2;
	localparam logic [7:0] MSK = cfr_pkg::IRQ_MASK_IDX << 2;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, strap_frame_enable;
	logic receive_half_full_irq, tx_en, tx_er, out_tx_en, frame_reg_wr;
	logic irq, go, bad, busy, tx_d, out_d, x;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tx_data, out_tx_data;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [31:0] seed = 32'd16178;
	logic [3:0] s_axi_wstrb, nbytes;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] own_phy_addr, frame_reg_addr;
	logic [15:0] frame_reg_data;
	logic [79:0] frame;
	logic [33:0] rd_q[$];
	logic [21:0] wr_q[$];
	int n_mismatch = 0, n_tests = 0, lag = 0, n_out = 0, exp_lag = 0, c, e;
	control_frame_register_writer #(.DEST_ADDR_A(DA_A), .DEST_ADDR_B(DA_B),
		.BUF_DEPTH(16)) i_dut (.*);
	cfr_mac_model i_mac (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bound(input int k);
		if (k >= 50) begin
			n_mismatch++;
			results();
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	always @(posedge aclk) begin
		lag = tx_en && !tx_d ? 0 : lag + 1;
		if (out_tx_en && !out_d)
			check(lag, exp_lag);
		if (out_tx_en)
			check(out_tx_data, frame[79 - 8 * n_out -: 8]);
		n_out += out_tx_en;
		tx_d = tx_en;
		out_d = out_tx_en;
		if (s_axi_rvalid && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
		if (frame_reg_wr)
			check({1'b1, frame_reg_addr, frame_reg_data}, wr_q.pop_front());
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_bvalid)
				break;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		bound(k);
		check(s_axi_bresp, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] ex);
		int k;
		@(posedge aclk);
		rd_q.push_back(ex);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_rvalid)
				break;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		bound(k);
	endtask
	task automatic send(input logic [47:0] da, input logic [4:0] tg,
		input logic [3:0] n, input logic w, input int o);
		int k;
		@(posedge aclk);
		seed = xs(seed);
		n_out = 0;
		frame <= {da, 3'h0, tg, 3'h0, seed[4:0], seed[31:16]};
		nbytes <= n;
		bad <= n < 4'ha;
		go <= 1'b1;
		if (w)
			wr_q.push_back({1'b1, seed[4:0], seed[31:16]});
		@(posedge aclk);
		go <= 1'b0;
		for (k = 0; k < 50 && (k < 2 || busy); k++)
			@(posedge aclk);
		bound(k);
		repeat (20) @(posedge aclk);
		check(n_out, o);
	endtask
	task automatic pulse();
		@(posedge aclk);
		receive_half_full_irq <= 1'b1;
		@(posedge aclk);
		receive_half_full_irq <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, receive_half_full_irq, go, bad} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{frame, nbytes} = 84'h0;
		{aresetn, strap_frame_enable, own_phy_addr} = 7'h25;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CFG, 34'h1);
		wr(CFG, 32'hffff, 2'h0);
		rd(CFG, 34'h1ff);
		wr(8'hf0, 32'h1, 2'h2);
		rd(8'hf0, 34'h200000000);
		exp_lag = 16;
		wr(CFG, 32'h1f, 2'h0);
		send(DA_A, 5'h05, 4'ha, 1'b1, 10);
		rd(CFG, 34'h401f);
		send(DA_A, 5'h05, 4'h8, 1'b0, 8);
		rd(CFG, 34'h801f);
		send(DA_A | 48'h010000000000, 5'h1f, 4'ha, 1'b1, 10);
		rd(CFG, 34'h401f);
		wr(CFG, 32'h13f, 2'h0);
		send(DA_A, 5'h05, 4'ha, 1'b0, 10);
		send(DA_B, 5'h1f, 4'ha, 1'b0, 10);
		send(DA_B, 5'h05, 4'ha, 1'b1, 10);
		rd(CFG, 34'h413f);
		exp_lag = 1;
		wr(CFG, 32'h101, 2'h0);
		send(DA_A, 5'h05, 4'ha, 1'b0, 10);
		send(DA_B, 5'h05, 4'ha, 1'b1, 6);
		exp_lag = 16;
		wr(MSK, 32'h1, 2'h0);
		for (c = 0; c < 4; c++) begin
			wr(CFG, {24'h0, c[1:0], 6'h1f}, 2'h0);
			for (e = 0; e < 3; e++) begin
				x = e == 0 ? c == 0 : c[e - 1];
				if (e == 0)
					pulse();
				else
					send(DA_A, 5'h05, e == 1 ? 4'ha : 4'h8, e == 1, e == 1 ? 10 : 8);
				check(irq, x);
				rd(STS, {33'h0, x});
				wr(STS, 32'h1, 2'h0);
			end
		end
		wr(MSK, 32'h0, 2'h0);
		wr(CFG, 32'h1e, 2'h0);
		pulse();
		check(irq, 1'b0);
		rd(STS, 34'h1);
		send(DA_A, 5'h05, 4'ha, 1'b0, 10);
		results();
	end
endmodule
